// *** hdl/prcs_top.sv ***
// Overview of operation
// [R1] Key held one millisecond starts the regulators.
// [R2] Regulators stay on after key release.
// [R3] Software reads the live power key level.
// [R4] Low core voltage asserts internal reset.
// [R5] Key held 5.6 seconds forces reset.
// [R6] Software bit disables long-press reset.
// [R7] Watchdog expiry or reset pin resets.
// [R8] Reset keeps regulators on, restores voltages.
// [R9] Only shutdown write or supply loss powers off.
// [R10] I/O supply defaults to 1.8 V.
// [R11] Boot software selects I/O level from strap.
// [R12] Multiplier 1.0 to 8.0 in half steps.
// [R13] Software programs 60 MHz for USB.
// [R14] Reset pin stops clock buffer, powers down.
// [R15] USB suspend selects RTC clock, stops oscillator.
// [R16] Power-up leaves all GPIO high-impedance.
// [R17] Crystal-rate analog side, multiplied digital side.
// [R18] Alternate converter pins run at half rate.
// [R19] Core and I/O domains switch independently.
// [R20] RTC domain stays powered throughout.
// [R21] Debugger reset joins the other sources.
// [R22] Reset asserts asynchronously, releases synchronously.
`timescale 1ns/1ps
module prcs_top
    import prcs_pkg::*;
#(
    parameter int unsigned START_CYC = prcs_pkg::START_HOLD_CYC,
    parameter int unsigned LONG_CYC = prcs_pkg::LONG_PRESS_CYC
) (
    // Clock and supply-present reset.
    input wire logic core_clk_i,
    input wire logic rstn_i,
    // Reset sources and pins.
    input wire logic power_key_in_i,
    input wire logic core_low_i,
    input wire logic wdog_expire_i,
    input wire logic dbg_rst_req_i,
    input wire logic ext_reset_n_i,
    input wire logic io_voltage_strap_i,
    input wire logic usb_suspend_i,
    // Alternate converter pins.
    input wire logic adc_bitstream_in_1_i,
    input wire logic adc_bitstream_in_2_i,
    input wire logic adc_bitstream_in_3_i,
    input wire logic dac_left_bit_i,
    input wire logic dac_right_bit_i,
    output logic dac_left_o,
    output logic dac_right_o,
    output logic [2:0] adc_bits_o,
    // Register port.
    input wire logic [prcs_pkg::ADDR_W-1:0] addr_i,
    input wire logic [prcs_pkg::DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [prcs_pkg::DATA_W-1:0] rdata_o,
    // Power, reset and clock controls.
    output logic sys_rst_n_o,
    output logic regs_on_o,
    output logic core_dom_on_o,
    output logic io_dom_on_o,
    output logic rtc_dom_on_o,
    output logic [prcs_pkg::VSEL_W-1:0] core_vsel_o,
    output logic [prcs_pkg::VSEL_W-1:0] ana_vsel_o,
    output logic io_3v3_o,
    output logic [prcs_pkg::PLL_W-1:0] pll_code_o,
    output logic clk_buf_en_o,
    output logic dig_pd_o,
    output logic clk_src_rtc_o,
    output logic osc_pd_o,
    output logic gpio_hiz_o,
    output logic io_leak_cut_o
);
    import prcs_pkg::*;

    typedef struct packed {
        logic regs_on;
        logic start_q;
        logic lp_q;
        logic [REQ_W-1:0] req_cnt;
        logic req_act;
        logic lp_dis;
        logic core_off;
        logic io_off;
        logic gpio_rel;
        logic alt_en;
        logic [VSEL_W-1:0] core_vsel;
        logic [VSEL_W-1:0] ana_vsel;
        logic io_3v3;
        logic [PLL_W-1:0] pll_code;
        logic [CAUSE_W-1:0] cause;
        logic [DATA_W-1:0] rdata;
        logic core_on;
        logic io_on;
        logic rtc_on;
        logic gpio_hiz;
        logic clk_buf_en;
        logic dig_pd;
        logic clk_rtc;
        logic osc_pd;
        logic div;
        logic dac_l;
        logic dac_r;
        logic [2:0] adc;
    } prcs_state_t;

    prcs_state_t st_ff, nxt_st;
    logic pwr_rst_n;
    logic sys_rst_n;
    logic sys_arst_n;
    logic start_done;
    logic lp_done;
    logic start_rise;
    logic lp_rise;
    logic trig;
    logic wr_ok;
    logic [CAUSE_W-1:0] cause_set;

    initial begin
        if (START_CYC < 2 || LONG_CYC < 2) $error("prcs_top hold counts must be two or more.");
        if (RST_STRETCH_CYC >= (1 << REQ_W)) $error("prcs_top stretch count does not fit.");
    end

    // Supply-present reset: the only event besides a shutdown write that drops the regulators.
    prcs_rst_sync #(.STAGES(RST_STAGES)) u_pwr_sync (
        .clk_i(core_clk_i),
        .arst_n_i(rstn_i),
        .rst_n_o(pwr_rst_n)
    );

    // Combined reset; supply loss, core monitor and pin pull it low at once, stretched requests one cycle later; release is clocked. [R22]
    assign sys_arst_n = pwr_rst_n & ~core_low_i & ext_reset_n_i & ~st_ff.req_act & st_ff.regs_on; // [R4] [R7]

    prcs_rst_sync #(.STAGES(RST_STAGES)) u_sys_sync (
        .clk_i(core_clk_i),
        .arst_n_i(sys_arst_n),
        .rst_n_o(sys_rst_n)
    );

    prcs_hold_cnt #(.COUNT(START_CYC)) u_start_cnt (
        .clk_i(core_clk_i),
        .rst_n_i(pwr_rst_n),
        .lvl_i(power_key_in_i),
        .done_o(start_done)
    );

    prcs_hold_cnt #(.COUNT(LONG_CYC)) u_long_cnt (
        .clk_i(core_clk_i),
        .rst_n_i(pwr_rst_n),
        .lvl_i(power_key_in_i & st_ff.regs_on),
        .done_o(lp_done)
    );

    always_comb begin
        nxt_st = st_ff;
        wr_ok = wr_i & sys_rst_n;
        // Edges only: a key still held after shutdown must be released before it restarts.
        start_rise = start_done & ~st_ff.start_q;
        lp_rise = lp_done & ~st_ff.lp_q;
        nxt_st.start_q = start_done;
        nxt_st.lp_q = lp_done;

        if (start_rise) begin
            nxt_st.regs_on = 1'b1; // [R1] [R2]
        end
        if (wr_ok && addr_i == ADDR_CTRL && wdata_i[CTRL_SHDN_HI:CTRL_SHDN_LO] == SHDN_CODE) begin
            nxt_st.regs_on = 1'b0; // [R9]
        end

        trig = wdog_expire_i | dbg_rst_req_i | (lp_rise & ~st_ff.lp_dis); // [R5] [R6] [R7] [R21]
        if (trig) begin
            nxt_st.req_cnt = REQ_W'(RST_STRETCH_CYC);
        end else if (st_ff.req_cnt != '0) begin
            nxt_st.req_cnt = st_ff.req_cnt - 1'b1;
        end
        nxt_st.req_act = (nxt_st.req_cnt != '0);

        // Cause flags survive the system reset; a new event beats a clear in the same cycle.
        cause_set = {lp_rise & ~st_ff.lp_dis, dbg_rst_req_i, wdog_expire_i, ~ext_reset_n_i, core_low_i};
        if (wr_ok && addr_i == ADDR_CAUSE) begin
            nxt_st.cause = st_ff.cause & ~wdata_i[CAUSE_W-1:0];
        end
        nxt_st.cause = nxt_st.cause | cause_set;

        // Settings go back to defaults while reset is held; the regulators keep running. [R8]
        if (!sys_rst_n) begin
            nxt_st.lp_dis = 1'b0;
            nxt_st.core_off = 1'b0;
            nxt_st.io_off = 1'b0;
            nxt_st.gpio_rel = 1'b0; // [R16]
            nxt_st.alt_en = 1'b0;
            nxt_st.core_vsel = CORE_VSEL_RST;
            nxt_st.ana_vsel = ANA_VSEL_RST;
            nxt_st.io_3v3 = IO_3V3_RST; // [R10]
            nxt_st.pll_code = PLL_CODE_RST;
        end else if (wr_ok) begin
            case (addr_i)
                ADDR_CTRL: begin
                    nxt_st.lp_dis = wdata_i[CTRL_LP_DIS]; // [R6]
                    nxt_st.core_off = wdata_i[CTRL_CORE_OFF];
                    nxt_st.io_off = wdata_i[CTRL_IO_OFF];
                    nxt_st.gpio_rel = wdata_i[CTRL_GPIO_REL];
                    nxt_st.alt_en = wdata_i[CTRL_ALT_EN];
                end
                ADDR_VOLT: begin
                    nxt_st.core_vsel = wdata_i[VOLT_CORE_LO +: VSEL_W];
                    nxt_st.ana_vsel = wdata_i[VOLT_ANA_LO +: VSEL_W];
                    nxt_st.io_3v3 = wdata_i[VOLT_IO_3V3]; // [R11]
                end
                ADDR_PLL: begin
                    // Codes above the top factor are dropped; the old factor stays. [R12] [R13]
                    if (wdata_i[PLL_W-1:0] <= PLL_CODE_MAX) begin
                        nxt_st.pll_code = wdata_i[PLL_W-1:0];
                    end
                end
                default: begin
                end
            endcase
        end

        nxt_st.core_on = st_ff.regs_on & ~st_ff.core_off; // [R19]
        nxt_st.io_on = st_ff.regs_on & ~st_ff.io_off; // [R19]
        nxt_st.rtc_on = 1'b1; // [R20]
        nxt_st.gpio_hiz = ~st_ff.gpio_rel; // [R16]
        nxt_st.clk_buf_en = ext_reset_n_i; // [R14]
        nxt_st.dig_pd = ~ext_reset_n_i; // [R14]
        nxt_st.clk_rtc = usb_suspend_i; // [R15]
        nxt_st.osc_pd = usb_suspend_i; // [R15]

        // This block runs at crystal rate; the halving enable paces the converter bits. [R17] [R18]
        nxt_st.div = ~st_ff.div;
        if (st_ff.div && st_ff.alt_en) begin
            nxt_st.dac_l = dac_left_bit_i;
            nxt_st.dac_r = dac_right_bit_i;
            nxt_st.adc = {adc_bitstream_in_3_i, adc_bitstream_in_2_i, adc_bitstream_in_1_i};
        end

        nxt_st.rdata = '0;
        if (rd_i) begin
            case (addr_i)
                ADDR_CTRL: begin
                    nxt_st.rdata[CTRL_LP_DIS] = st_ff.lp_dis;
                    nxt_st.rdata[CTRL_CORE_OFF] = st_ff.core_off;
                    nxt_st.rdata[CTRL_IO_OFF] = st_ff.io_off;
                    nxt_st.rdata[CTRL_GPIO_REL] = st_ff.gpio_rel;
                    nxt_st.rdata[CTRL_ALT_EN] = st_ff.alt_en;
                end
                ADDR_VOLT: begin
                    nxt_st.rdata[VOLT_CORE_LO +: VSEL_W] = st_ff.core_vsel;
                    nxt_st.rdata[VOLT_ANA_LO +: VSEL_W] = st_ff.ana_vsel;
                    nxt_st.rdata[VOLT_IO_3V3] = st_ff.io_3v3;
                end
                ADDR_PLL: begin
                    nxt_st.rdata[PLL_W-1:0] = st_ff.pll_code;
                end
                ADDR_STATUS: begin
                    nxt_st.rdata[STAT_KEY] = power_key_in_i; // [R3]
                    nxt_st.rdata[STAT_STRAP] = io_voltage_strap_i;
                    nxt_st.rdata[STAT_REGS_ON] = st_ff.regs_on;
                    nxt_st.rdata[STAT_CLK_RTC] = st_ff.clk_rtc;
                end
                ADDR_CAUSE: begin
                    nxt_st.rdata[CAUSE_W-1:0] = st_ff.cause;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge pwr_rst_n) begin
        if (!pwr_rst_n) begin
            st_ff <= '{
                core_vsel: CORE_VSEL_RST,
                ana_vsel: ANA_VSEL_RST,
                io_3v3: IO_3V3_RST,
                pll_code: PLL_CODE_RST,
                gpio_hiz: 1'b1,
                dig_pd: 1'b1,
                rtc_on: 1'b1,
                default: '0
            };
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign dac_left_o = st_ff.dac_l;
    assign dac_right_o = st_ff.dac_r;
    assign adc_bits_o = st_ff.adc;
    assign rdata_o = st_ff.rdata;
    assign sys_rst_n_o = sys_rst_n;
    assign regs_on_o = st_ff.regs_on;
    assign core_dom_on_o = st_ff.core_on;
    assign io_dom_on_o = st_ff.io_on;
    assign rtc_dom_on_o = st_ff.rtc_on;
    assign core_vsel_o = st_ff.core_vsel;
    assign ana_vsel_o = st_ff.ana_vsel;
    assign io_3v3_o = st_ff.io_3v3;
    assign pll_code_o = st_ff.pll_code;
    assign clk_buf_en_o = st_ff.clk_buf_en;
    assign dig_pd_o = st_ff.dig_pd;
    assign clk_src_rtc_o = st_ff.clk_rtc;
    assign osc_pd_o = st_ff.osc_pd;
    assign gpio_hiz_o = st_ff.gpio_hiz;
    assign io_leak_cut_o = st_ff.gpio_hiz;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!pwr_rst_n);

    start_latch_a: assert property ($rose(start_done) && !st_ff.regs_on |=> regs_on_o) // [R1]
        else $error("Regulators did not start after key hold.");
    regs_hold_a: assert property (regs_on_o && !(wr_ok && addr_i == ADDR_CTRL) |=> regs_on_o) // [R2] [R8] [R9]
        else $error("Regulators dropped without shutdown write.");
    key_read_a: assert property (rd_i && addr_i == ADDR_STATUS |=> rdata_o[STAT_KEY] == $past(power_key_in_i)) // [R3]
        else $error("Status did not show the key level.");
    core_low_a: assert property (core_low_i |-> ##[0:1] !sys_rst_n_o) // [R4] [R22]
        else $error("Low core voltage did not reset.");
    long_press_a: assert property ($rose(lp_done) && !st_ff.lp_dis |-> ##[1:3] !sys_rst_n_o) // [R5] [R6]
        else $error("Long press did not reset.");
    wdog_rst_a: assert property (wdog_expire_i || dbg_rst_req_i |-> ##[1:3] !sys_rst_n_o) // [R7] [R21]
        else $error("Watchdog or debugger did not reset.");
    volt_default_a: assert property (!sys_rst_n_o |=> core_vsel_o == CORE_VSEL_RST && !io_3v3_o) // [R8] [R10]
        else $error("Voltage settings not restored in reset.");
    pll_range_a: assert property (pll_code_o <= PLL_CODE_MAX) // [R12]
        else $error("Multiplier code out of range.");
    clk_gate_a: assert property (!ext_reset_n_i |=> !clk_buf_en_o && dig_pd_o && !sys_rst_n_o) // [R14] [R7]
        else $error("Reset pin did not stop the clock buffer.");
    suspend_clk_a: assert property (usb_suspend_i |=> clk_src_rtc_o && osc_pd_o) // [R15]
        else $error("Suspend did not select the RTC clock.");
    domain_sep_a: assert property (regs_on_o && $past(regs_on_o) |-> core_dom_on_o == !$past(st_ff.core_off)) // [R19]
        else $error("Core domain switch wrong.");
    io_dom_a: assert property (regs_on_o && $past(regs_on_o) |-> io_dom_on_o == !$past(st_ff.io_off)) // [R19]
        else $error("I/O domain switch wrong.");
    hiz_reset_a: assert property (!sys_rst_n_o |=> ##1 gpio_hiz_o && io_leak_cut_o) // [R16]
        else $error("Pins not floated after reset.");

    start_cov_c: cover property ($rose(regs_on_o));
    shutdown_cov_c: cover property ($fell(regs_on_o));
    long_cov_c: cover property ($rose(lp_done) && !st_ff.lp_dis);
    suspend_cov_c: cover property ($rose(clk_src_rtc_o));
    pin_cov_c: cover property (!ext_reset_n_i ##1 !clk_buf_en_o);
endmodule // prcs_top

// *** inc/prcs_pkg.sv ***
package prcs_pkg;
    // Clock rate and the figures that turn into cycle counts.
    localparam int unsigned CLK_KHZ = 40000;
    localparam int unsigned START_HOLD_US = 1000;
    localparam int unsigned START_HOLD_CYC = (START_HOLD_US * CLK_KHZ + 999) / 1000;
    localparam int unsigned LONG_PRESS_MS = 5600;
    localparam int unsigned LONG_PRESS_CYC = LONG_PRESS_MS * CLK_KHZ;
    localparam int unsigned RST_STRETCH_CYC = 16;
    localparam int unsigned REQ_W = 5;
    localparam int unsigned RST_STAGES = 2;

    // Register port.
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_VOLT = 8'h04;
    localparam logic [7:0] ADDR_PLL = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_CAUSE = 8'h10;

    // Control register fields.
    localparam int unsigned CTRL_LP_DIS = 0;
    localparam int unsigned CTRL_CORE_OFF = 1;
    localparam int unsigned CTRL_IO_OFF = 2;
    localparam int unsigned CTRL_GPIO_REL = 3;
    localparam int unsigned CTRL_SHDN_LO = 4;
    localparam int unsigned CTRL_SHDN_HI = 5;
    localparam int unsigned CTRL_ALT_EN = 6;
    localparam logic [1:0] SHDN_CODE = 2'h3;

    // Voltage register fields and defaults.
    localparam int unsigned VSEL_W = 4;
    localparam int unsigned VOLT_CORE_LO = 0;
    localparam int unsigned VOLT_ANA_LO = 4;
    localparam int unsigned VOLT_IO_3V3 = 8;
    localparam logic [3:0] CORE_VSEL_RST = 4'h8;
    localparam logic [3:0] ANA_VSEL_RST = 4'h6;
    localparam logic IO_3V3_RST = 1'b0;

    // Multiplier code: factor = 1.0 + 0.5 * code.
    localparam int unsigned PLL_W = 4;
    localparam logic [3:0] PLL_CODE_RST = 4'h0;
    localparam logic [3:0] PLL_CODE_MAX = 4'hE;

    // Status and cause bits.
    localparam int unsigned STAT_KEY = 0;
    localparam int unsigned STAT_STRAP = 1;
    localparam int unsigned STAT_REGS_ON = 2;
    localparam int unsigned STAT_CLK_RTC = 3;
    localparam int unsigned CAUSE_W = 5;
endpackage

// *** hdl/prcs_rst_sync.sv ***
`timescale 1ns/1ps
module prcs_rst_sync #(
    parameter int unsigned STAGES = 2
) (
    // Clock and asynchronous reset request.
    input wire logic clk_i,
    input wire logic arst_n_i,
    // Released reset.
    output logic rst_n_o
);
    typedef struct packed {
        logic [STAGES-1:0] sh;
    } prcs_sync_t;

    prcs_sync_t st_ff, nxt_st;

    initial begin
        if (STAGES < 2) $error("prcs_rst_sync needs at least two stages.");
    end

    always_comb begin
        nxt_st = st_ff;
        nxt_st.sh = {st_ff.sh[STAGES-2:0], 1'b1};
    end

    // Assertion is immediate; release walks through the chain.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign rst_n_o = st_ff.sh[STAGES-1];
endmodule // prcs_rst_sync

// *** hdl/prcs_hold_cnt.sv ***
`timescale 1ns/1ps
module prcs_hold_cnt #(
    parameter int unsigned COUNT = 40000,
    parameter int unsigned CNT_W = $clog2(COUNT + 1)
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Level watched and its held flag.
    input wire logic lvl_i,
    output logic done_o
);
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic done;
    } prcs_hold_t;

    prcs_hold_t st_ff, nxt_st;

    initial begin
        if (COUNT < 2) $error("prcs_hold_cnt needs COUNT of two or more.");
    end

    // Any low cycle restarts the count, so only an unbroken hold counts.
    always_comb begin
        nxt_st = st_ff;
        if (!lvl_i) begin
            nxt_st.cnt = '0;
            nxt_st.done = 1'b0;
        end else if (st_ff.cnt == CNT_W'(COUNT - 1)) begin
            nxt_st.done = 1'b1;
        end else begin
            nxt_st.cnt = st_ff.cnt + 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign done_o = st_ff.done;
endmodule // prcs_hold_cnt

// *** bench/prcs_far_model.sv ***
`timescale 1ns/1ps
// Power key, reset pin and strap as they sit on the board.
module prcs_far_model #(
    parameter int unsigned BOUNCE = 4
) (
    // Clock.
    input wire logic clk_i,
    // Commands from the bench.
    input wire logic press_i,
    input wire logic pin_rst_i,
    input wire logic strap_up_i,
    // Board-side levels.
    output logic key_o,
    output logic ext_reset_n_o,
    output logic strap_o
);
    int unsigned bcnt = 0;
    logic press_ff = 1'b0;
    logic key_ff = 1'b0;

    // A real key chatters after it is pressed, so a start counter that ignores lows is caught.
    always @(posedge clk_i) begin
        press_ff <= press_i;
        if (press_i && !press_ff) begin
            bcnt <= BOUNCE;
        end else if (bcnt != 0) begin
            bcnt <= bcnt - 1;
        end
        key_ff <= press_i && (bcnt == 0 || bcnt[0]);
    end

    assign key_o = key_ff;

    // The reset pin has a pull-up, so it reads high whenever nobody pulls it.
    assign ext_reset_n_o = ~pin_rst_i;
    assign strap_o = strap_up_i;
endmodule // prcs_far_model

// *** bench/power_reset_clock_sequencer_test.sv ***
`timescale 1ns/1ps
module power_reset_clock_sequencer_test;
    import prcs_pkg::*;
    localparam int unsigned START = 8;
    localparam int unsigned LONG = 40;
    localparam int unsigned BOUNCE = 4;
    logic core_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic press = 1'b0, pin_rst = 1'b0, strap_up = 1'b1, key, ext_n, strap;
    logic core_low = 1'b0, wdog = 1'b0, dbg = 1'b0, usb = 1'b0, dac_l = 1'b0, dac_r = 1'b0;
    logic [2:0] adc_in = 3'h0;
    logic [2:0] adc_o;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic wr = 1'b0, rd = 1'b0;
    logic dac_l_o, dac_r_o, sys_rst_n, regs_on, core_on, io_on, rtc_on, io_3v3, clk_buf_en, dig_pd;
    logic clk_rtc, osc_pd, gpio_hiz, leak_cut;
    logic [3:0] core_vsel, ana_vsel, pll_code;
    int error_cnt = 0;
    int n_compared = 0;

    prcs_far_model #(.BOUNCE(BOUNCE)) far (.clk_i(core_clk_i), .press_i(press), .pin_rst_i(pin_rst),
        .strap_up_i(strap_up), .key_o(key), .ext_reset_n_o(ext_n), .strap_o(strap));

    prcs_top #(.START_CYC(START), .LONG_CYC(LONG)) dut (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
        .power_key_in_i(key), .core_low_i(core_low), .wdog_expire_i(wdog), .dbg_rst_req_i(dbg),
        .ext_reset_n_i(ext_n), .io_voltage_strap_i(strap), .usb_suspend_i(usb),
        .adc_bitstream_in_1_i(adc_in[0]), .adc_bitstream_in_2_i(adc_in[1]), .adc_bitstream_in_3_i(adc_in[2]),
        .dac_left_bit_i(dac_l), .dac_right_bit_i(dac_r), .dac_left_o(dac_l_o), .dac_right_o(dac_r_o),
        .adc_bits_o(adc_o), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
        .sys_rst_n_o(sys_rst_n), .regs_on_o(regs_on), .core_dom_on_o(core_on), .io_dom_on_o(io_on),
        .rtc_dom_on_o(rtc_on), .core_vsel_o(core_vsel), .ana_vsel_o(ana_vsel), .io_3v3_o(io_3v3),
        .pll_code_o(pll_code), .clk_buf_en_o(clk_buf_en), .dig_pd_o(dig_pd), .clk_src_rtc_o(clk_rtc),
        .osc_pd_o(osc_pd), .gpio_hiz_o(gpio_hiz), .io_leak_cut_o(leak_cut));

    initial begin
        forever #12.5 core_clk_i = ~core_clk_i;
    end

    task automatic wrap_up();
        if (error_cnt == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge core_clk_i);
        wr <= 1'b0;
        #1;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge core_clk_i);
        rd <= 1'b1;
        addr <= a;
        @(posedge core_clk_i);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask

    task automatic wait_rst(input logic lvl, input int lim);
        int i;
        for (i = 0; i < lim && sys_rst_n !== lvl; i++) begin
            tick(1);
        end
        chk(sys_rst_n, lvl);
        if (sys_rst_n !== lvl) wrap_up();
    endtask

    // Sources 0..3: core monitor, reset pin, watchdog, debugger.
    task automatic src_hit(input int s);
        wr_reg(ADDR_VOLT, 32'h123);
        @(posedge core_clk_i);
        core_low <= (s == 0);
        pin_rst <= (s == 1);
        wdog <= (s == 2);
        dbg <= (s == 3);
        #1;
        if (s < 2) chk(sys_rst_n, 32'h0);
        wait_rst(1'b0, 4);
        tick(1);
        chk(clk_buf_en, s != 1);
        chk(dig_pd, s == 1);
        @(posedge core_clk_i);
        core_low <= 1'b0;
        pin_rst <= 1'b0;
        wdog <= 1'b0;
        dbg <= 1'b0;
        #1;
        chk(sys_rst_n, 32'h0);
        wait_rst(1'b1, 40);
        chk(core_vsel, CORE_VSEL_RST);
        chk(ana_vsel, ANA_VSEL_RST);
        chk(io_3v3, 32'h0);
        chk(regs_on, 32'h1);
        rd_chk(ADDR_CAUSE, 32'h1 << s);
        wr_reg(ADDR_CAUSE, 32'h1F);
    endtask

    initial begin
        int n;
        logic last;
        tick(4);
        chk(sys_rst_n, 32'h0);
        chk(regs_on, 32'h0);
        chk(gpio_hiz, 32'h1);
        chk(leak_cut, 32'h1);
        chk(rtc_on, 32'h1);
        @(posedge core_clk_i);
        rstn_i <= 1'b1;
        tick(4);
        chk(regs_on, 32'h0);
        @(posedge core_clk_i);
        press <= 1'b1;
        n = 0;
        while (regs_on !== 1'b1 && n < 60) begin
            tick(1);
            n++;
        end
        chk(n >= START + BOUNCE + 1 && n <= START + BOUNCE + 7, 32'h1);
        @(posedge core_clk_i);
        press <= 1'b0;
        tick(20);
        chk(regs_on, 32'h1);
        wait_rst(1'b1, 40);
        wr_reg(ADDR_CAUSE, 32'h1F);
        rd_chk(ADDR_VOLT, 32'h68);
        rd_chk(8'h20, 32'h0);
        rd_chk(ADDR_STATUS, 32'h6);
        // Boot software picks the I/O level from the strap it just read.
        if (rdata[STAT_STRAP] === 1'b1) wr_reg(ADDR_VOLT, 32'h168);
        chk(io_3v3, 32'h1);
        for (int c = 0; c < 16; c++) begin
            wr_reg(ADDR_PLL, 32'(c));
            chk(pll_code, (c > 14) ? 32'hE : 32'(c));
        end
        wr_reg(ADDR_PLL, 32'h9);
        rd_chk(ADDR_PLL, 32'h9);
        for (int s = 0; s < 4; s++) src_hit(s);
        @(posedge core_clk_i);
        press <= 1'b1;
        wait_rst(1'b0, LONG + 20);
        @(posedge core_clk_i);
        press <= 1'b0;
        wait_rst(1'b1, 40);
        chk(regs_on, 32'h1);
        rd_chk(ADDR_CAUSE, 32'h10);
        wr_reg(ADDR_CTRL, 32'h1);
        @(posedge core_clk_i);
        press <= 1'b1;
        tick(8);
        rd_chk(ADDR_STATUS, 32'h7);
        n = 0;
        repeat (LONG + 20) begin
            tick(1);
            if (sys_rst_n !== 1'b1) n++;
        end
        chk(32'(n), 32'h0);
        @(posedge core_clk_i);
        press <= 1'b0;
        wr_reg(ADDR_CTRL, 32'h2);
        tick(2);
        chk(core_on, 32'h0);
        chk(io_on, 32'h1);
        wr_reg(ADDR_CTRL, 32'hC);
        tick(2);
        chk(core_on, 32'h1);
        chk(io_on, 32'h0);
        chk(gpio_hiz, 32'h0);
        chk(leak_cut, 32'h0);
        @(posedge core_clk_i);
        usb <= 1'b1;
        tick(2);
        chk(clk_rtc, 32'h1);
        chk(osc_pd, 32'h1);
        rd_chk(ADDR_STATUS, 32'hE);
        @(posedge core_clk_i);
        usb <= 1'b0;
        wr_reg(ADDR_CTRL, 32'h40);
        @(posedge core_clk_i);
        adc_in <= 3'h5;
        dac_l <= 1'b1;
        tick(4);
        chk(adc_o, 32'h5);
        chk(dac_l_o, 32'h1);
        chk(dac_r_o, 32'h0);
        // A bit that flips every cycle, taken every second cycle, always lands on the same phase.
        n = 0;
        last = dac_l_o;
        for (int i = 0; i < 11; i++) begin
            @(posedge core_clk_i);
            dac_l <= ~dac_l;
            #1;
            if (i > 2 && dac_l_o !== last) n++;
            last = dac_l_o;
        end
        chk(32'(n), 32'h0);
        wr_reg(ADDR_CTRL, 32'h30);
        tick(2);
        chk(regs_on, 32'h0);
        chk(sys_rst_n, 32'h0);
        wrap_up();
    end
endmodule // power_reset_clock_sequencer_test
